/* File: common/upfp_pkg.sv */
// shared constants and types for the parallel fifo port
package upfp_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int FLAG_RECOV_NS  = 80;
  localparam int FLAG_RECOV_CYC =
    (FLAG_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS      = 50;
  localparam int STROBE_CYC     =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYC         = MS_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // flush timeout in milliseconds
  // ----------------------------------------------------------------
  localparam logic [7:0] TMO_DFLT_MS = 8'h10;
  localparam logic [7:0] TMO_MIN_MS  = 8'h01;

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  localparam int RX_AW    = 4;
  localparam int RX_DEPTH = 1 << RX_AW;
  localparam int TX_AW    = 6;
  localparam int TX_DEPTH = 1 << TX_AW;

  // arbitrary value, not a real part identity
  localparam logic [31:0] CHIP_ID_DFLT = 32'h5a3c_0001;

  // ----------------------------------------------------------------
  // host controller timing, in clock cycles
  // ----------------------------------------------------------------
  localparam int HOST_WR_CYC  = STROBE_CYC + 1;
  localparam int HOST_RD_CYC  = 4;
  localparam int HOST_GAP_CYC = FLAG_RECOV_CYC + 4;

  // ----------------------------------------------------------------
  // host register map (apb)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STAT_OFS      = 8'h04;
  localparam int         CTRL_WR_BIT   = 0;
  localparam int         CTRL_RD_BIT   = 1;
  localparam int         CTRL_WAKE_BIT = 2;
  localparam int         DATA_LSB      = 8;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_RXA_BIT  = 1;
  localparam int         STAT_TXS_BIT  = 2;
  localparam int         STAT_PWR_BIT  = 3;
  localparam int         STAT_DONE_BIT = 4;

  typedef enum logic {TX_FILL, TX_FLUSH} upfp_tx_state_t;
  typedef enum logic [2:0] {
    H_IDLE, H_WAIT_TX, H_WR, H_WR_HOLD, H_WAIT_RX, H_RD, H_WAKE, H_GAP
  } upfp_host_state_t;

endpackage

/* File: common/upfp_if.sv */
// link between the fifo port device and its external controller
`timescale 1ns/1ps
interface upfp_if;
  logic       rd_n;
  logic       wr;
  logic [7:0] hdata_o;
  logic       hdata_oe;
  logic       hrxf_o;
  logic       hrxf_oe;
  logic [7:0] ddata_o;
  logic       ddata_oe;
  logic       rxa_o;
  logic       rxa_oe;
  logic       txf_o;
  logic       txf_oe;
  logic       power_switch_n;
  logic       pd_en;
  logic [7:0] fifo_data_bus;
  logic       rx_avail_n;
  logic       tx_space_n;

  // weak pull-ups on the lines, weak pull-down on data when selected
  assign fifo_data_bus = ddata_oe ? ddata_o :
                         (hdata_oe ? hdata_o : (pd_en ? 8'h00 : 8'hff));
  assign rx_avail_n    = rxa_oe ? rxa_o : (hrxf_oe ? hrxf_o : 1'b1);
  assign tx_space_n    = txf_oe ? txf_o : 1'b1;

  modport dev (input rd_n, wr, fifo_data_bus, rx_avail_n,
               output ddata_o, ddata_oe, rxa_o, rxa_oe, txf_o, txf_oe,
               power_switch_n, pd_en);
  modport host (input fifo_data_bus, rx_avail_n, tx_space_n,
                power_switch_n,
                output rd_n, wr, hdata_o, hdata_oe, hrxf_o, hrxf_oe);
endinterface

/* File: design/upfp_sync.sv */
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module upfp_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST;
      q       <= RST;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

/* File: design/upfp_device.sv */
// usb side of the parallel fifo port: buffers, flags, power, wake
//
// Behaviour
// [R1] suspended with wake on: receive flag becomes wake input
// [R2] flush timeout 16ms default, 1..255ms settable
// [R3] timeout sends partial transmit data to usb
// [R4] power switch low when configured, high in suspend
// [R5] pull-down option bleeds lines while power off
// [R6] drive receive byte while read strobe low
// [R7] read strobe falling edge pops next byte
// [R8] write strobe falling edge captures data bus
// [R9] write only while transmit-space flag low
// [R10] read only while receive-available flag low
// [R11] flags undriven during reset
// [R12] read strobe low at least 50ns
// [R13] read strobe high 50ns plus recovery
// [R14] receive flag high 80ns after each read
// [R15] write strobe active at least 50ns
// [R16] write strobe precharge at least 50ns
// [R17] transmit flag high 80ns after each write
// [R18] fixed chip id, readable, never rewritable
// [R19] data bus undriven while read strobe high
// [R20] strobes synchronised before touching pointers
`timescale 1ns/1ps
module upfp_device #(
  parameter int          MS_CYCLES = upfp_pkg::MS_CYC,
  parameter logic [31:0] CHIP_ID   = upfp_pkg::CHIP_ID_DFLT
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  upfp_if.dev              link,
  input  wire logic        USB_RX_VALID,
  input  wire logic [7:0]  USB_RX_DATA,
  output logic             USB_RX_READY,
  output logic             USB_TX_VALID,
  output logic [7:0]       USB_TX_DATA,
  input  wire logic        USB_TX_READY,
  input  wire logic        USB_CONFIGURED,
  input  wire logic        USB_SUSPEND,
  input  wire logic        WAKE_ENABLE,
  input  wire logic        PULLDOWN_OPT,
  input  wire logic        TIMEOUT_SET,
  input  wire logic [7:0]  TIMEOUT_MS,
  output logic             USB_RESUME,
  output logic [31:0]      CHIP_ID_OUT
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  // data travels with the strobes so the byte seen with the last high
  // write sample is the one that had setup before the falling edge
  logic [10:0] pin_s;
  logic [10:0] hist_ff;
  logic        rd_n_s;
  logic        wr_s;
  logic        rxpin_s;
  logic [7:0]  data_s;

  upfp_sync #(.W(11), .RST(11'h600)) u_sync (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .d     ({link.rd_n, link.rx_avail_n, link.wr, link.fifo_data_bus}),
    .q     (pin_s)
  ); // [R20]

  assign rd_n_s  = pin_s[10];
  assign rxpin_s = pin_s[9];
  assign wr_s    = pin_s[8];
  assign data_s  = pin_s[7:0];

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      hist_ff <= 11'h600;
    end else begin
      hist_ff <= pin_s;
    end
  end

  logic rd_fall;
  logic wr_rise;
  logic wr_fall;
  logic wake_fall;
  assign rd_fall   = hist_ff[10] & ~rd_n_s; // [R7]
  assign wake_fall = hist_ff[9] & ~rxpin_s;
  assign wr_rise   = ~hist_ff[8] & wr_s;
  assign wr_fall   = hist_ff[8] & ~wr_s; // [R8]

  // ----------------------------------------------------------------
  // receive buffer (usb to external logic)
  // ----------------------------------------------------------------
  logic [7:0]       rx_mem [upfp_pkg::RX_DEPTH];
  logic [upfp_pkg::RX_AW:0] rx_wp_ff;
  logic [upfp_pkg::RX_AW:0] rx_rp_ff;
  logic [upfp_pkg::RX_AW:0] rx_cnt;
  logic             rx_push;
  logic             rx_pop;
  logic [7:0]       dout_ff;
  logic             dout_oe_ff;

  assign rx_cnt  = rx_wp_ff - rx_rp_ff;
  assign rx_push = USB_RX_VALID & USB_RX_READY;
  assign rx_pop  = rd_fall & (rx_cnt != '0);

  always_ff @(posedge CLOCK) begin
    if (rx_push) begin
      rx_mem[rx_wp_ff[upfp_pkg::RX_AW-1:0]] <= USB_RX_DATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rx_wp_ff     <= '0;
      USB_RX_READY <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_wp_ff <= rx_wp_ff + 1'b1;
      end
      // one slot of margin covers the word accepted this cycle
      USB_RX_READY <= rx_cnt < (upfp_pkg::RX_AW+1)'(upfp_pkg::RX_DEPTH - 1);
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rx_rp_ff   <= '0;
      dout_ff    <= 8'h00;
      dout_oe_ff <= 1'b0;
    end else begin
      if (rx_pop) begin
        rx_rp_ff <= rx_rp_ff + 1'b1;
        dout_ff  <= rx_mem[rx_rp_ff[upfp_pkg::RX_AW-1:0]]; // [R7]
      end
      dout_oe_ff <= ~rd_n_s; // [R6] [R19]
    end
  end

  // ----------------------------------------------------------------
  // receive flag and wake input
  // ----------------------------------------------------------------
  logic [1:0] rx_hold_ff;
  logic       rx_busy_ff;
  logic       rxa_ff;
  logic       rxa_oe_ff;
  logic       wake_mode;

  assign wake_mode = USB_SUSPEND & WAKE_ENABLE;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rx_busy_ff <= 1'b0;
      rx_hold_ff <= '0;
      rxa_ff     <= 1'b1;
      rxa_oe_ff  <= 1'b0; // [R11]
      USB_RESUME <= 1'b0;
    end else begin
      if (rd_fall) begin
        rx_busy_ff <= 1'b1;
      end else if (rd_n_s) begin
        rx_busy_ff <= 1'b0;
      end
      if (!rd_n_s || rd_fall) begin
        rx_hold_ff <= 2'(upfp_pkg::FLAG_RECOV_CYC); // [R14]
      end else if (rx_hold_ff != '0) begin
        rx_hold_ff <= rx_hold_ff - 1'b1;
      end
      rxa_ff <= rx_busy_ff | rd_fall | (rx_hold_ff != '0) |
                (rx_cnt == '0) | (rx_cnt == 1 && rx_pop); // [R10] [R14]
      rxa_oe_ff  <= ~wake_mode; // [R1]
      // only a low strobe seen with the pin released counts as wake
      USB_RESUME <= wake_mode & ~rxa_oe_ff & wake_fall; // [R1]
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer (external logic to usb)
  // ----------------------------------------------------------------
  logic [7:0]       tx_mem [upfp_pkg::TX_DEPTH];
  logic [upfp_pkg::TX_AW:0] tx_wp_ff;
  logic [upfp_pkg::TX_AW:0] tx_rp_ff;
  logic [upfp_pkg::TX_AW:0] tx_cnt;
  logic             tx_push;
  logic             tx_full;
  upfp_pkg::upfp_tx_state_t tx_st_ff;

  assign tx_cnt  = tx_wp_ff - tx_rp_ff;
  assign tx_full = tx_cnt == (upfp_pkg::TX_AW+1)'(upfp_pkg::TX_DEPTH);
  assign tx_push = wr_fall & ~tx_full; // [R8]

  always_ff @(posedge CLOCK) begin
    if (tx_push) begin
      tx_mem[tx_wp_ff[upfp_pkg::TX_AW-1:0]] <= hist_ff[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tx_wp_ff <= '0;
    end else if (tx_push) begin
      tx_wp_ff <= tx_wp_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transmit flag
  // ----------------------------------------------------------------
  logic [1:0] tx_hold_ff;
  logic       tx_busy_ff;
  logic       txf_ff;
  logic       txf_oe_ff;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tx_busy_ff <= 1'b0;
      tx_hold_ff <= '0;
      txf_ff     <= 1'b1;
      txf_oe_ff  <= 1'b0; // [R11]
    end else begin
      if (wr_rise) begin
        tx_busy_ff <= 1'b1;
      end else if (wr_fall) begin
        tx_busy_ff <= 1'b0;
      end
      if (wr_s || wr_fall) begin
        tx_hold_ff <= 2'(upfp_pkg::FLAG_RECOV_CYC); // [R17]
      end else if (tx_hold_ff != '0) begin
        tx_hold_ff <= tx_hold_ff - 1'b1;
      end
      // the slot a write is about to fill counts as taken
      txf_ff <= wr_rise | tx_busy_ff | wr_fall | (tx_hold_ff != '0) |
                (tx_cnt >= (upfp_pkg::TX_AW+1)'(upfp_pkg::TX_DEPTH - 1));
      txf_oe_ff <= 1'b1; // [R9]
    end
  end

  // ----------------------------------------------------------------
  // flush timeout
  // ----------------------------------------------------------------
  logic [7:0]  tmo_ms_ff;
  logic [31:0] cyc_ff;
  logic [7:0]  ms_ff;
  logic        ms_tick;

  assign ms_tick = cyc_ff == 32'(MS_CYCLES - 1);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tmo_ms_ff <= upfp_pkg::TMO_DFLT_MS; // [R2]
    end else if (TIMEOUT_SET) begin
      // zero is out of range, so it clamps to the shortest step
      tmo_ms_ff <= (TIMEOUT_MS < upfp_pkg::TMO_MIN_MS) ?
                   upfp_pkg::TMO_MIN_MS : TIMEOUT_MS; // [R2]
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cyc_ff <= '0;
      ms_ff  <= '0;
    end else if (tx_push || tx_st_ff == upfp_pkg::TX_FLUSH) begin
      cyc_ff <= '0;
      ms_ff  <= '0;
    end else if (ms_tick) begin
      cyc_ff <= '0;
      if (ms_ff != 8'hff) begin
        ms_ff <= ms_ff + 1'b1;
      end
    end else begin
      cyc_ff <= cyc_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transmit drain toward usb
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      tx_st_ff     <= upfp_pkg::TX_FILL;
      tx_rp_ff     <= '0;
      USB_TX_VALID <= 1'b0;
      USB_TX_DATA  <= 8'h00;
    end else begin
      case (tx_st_ff)
        upfp_pkg::TX_FILL: begin
          if (tx_full || (tx_cnt != '0 && ms_ff >= tmo_ms_ff)) begin
            tx_st_ff <= upfp_pkg::TX_FLUSH; // [R3]
          end
        end
        upfp_pkg::TX_FLUSH: begin
          if (!USB_TX_VALID || USB_TX_READY) begin
            if (tx_cnt != '0) begin
              USB_TX_VALID <= 1'b1;
              USB_TX_DATA  <= tx_mem[tx_rp_ff[upfp_pkg::TX_AW-1:0]];
              tx_rp_ff     <= tx_rp_ff + 1'b1; // [R3]
            end else begin
              USB_TX_VALID <= 1'b0;
              tx_st_ff     <= upfp_pkg::TX_FILL;
            end
          end
        end
        default: begin
          tx_st_ff <= upfp_pkg::TX_FILL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power switch, pull-down and chip id
  // ----------------------------------------------------------------
  logic pwr_n_ff;
  logic pd_ff;
  logic nxt_pwr_n;

  always_comb begin
    nxt_pwr_n = pwr_n_ff;
    if (USB_SUSPEND) begin
      nxt_pwr_n = 1'b1; // [R4]
    end else if (USB_CONFIGURED) begin
      nxt_pwr_n = 1'b0; // [R4]
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pwr_n_ff <= 1'b1;
      pd_ff    <= 1'b0;
    end else begin
      pwr_n_ff <= nxt_pwr_n;
      // same edge as power, so the pull-down never overlaps power on
      pd_ff    <= PULLDOWN_OPT & nxt_pwr_n; // [R5]
    end
  end

  // loaded only by reset, no write path exists
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      CHIP_ID_OUT <= CHIP_ID; // [R18]
    end else begin
      CHIP_ID_OUT <= CHIP_ID_OUT;
    end
  end

  assign link.ddata_o        = dout_ff;
  assign link.ddata_oe       = dout_oe_ff;
  assign link.rxa_o          = rxa_ff;
  assign link.rxa_oe         = rxa_oe_ff;
  assign link.txf_o          = txf_ff;
  assign link.txf_oe         = txf_oe_ff;
  assign link.power_switch_n = pwr_n_ff;
  assign link.pd_en          = pd_ff;

endmodule

/* File: design/upfp_host.sv */
// external controller end, driven by software over apb
`timescale 1ns/1ps
module upfp_host (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  upfp_if.host             link,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  upfp_pkg::upfp_host_state_t st_ff;
  logic       setup;
  logic       ctrl_wr;
  logic       done_ff;
  logic [7:0] rdata_ff;
  logic [7:0] wdata_ff;
  logic       idle;

  assign setup   = PSEL & ~PENABLE;
  assign idle    = st_ff == upfp_pkg::H_IDLE;
  // orders act at the access edge, where the master sees pready
  assign ctrl_wr = PSEL & PENABLE & PREADY & PWRITE &
                   (PADDR == upfp_pkg::CTRL_OFS);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & (PADDR != upfp_pkg::CTRL_OFS) &
                 (PADDR != upfp_pkg::STAT_OFS);
      PRDATA  <= '0;
      if (setup && !PWRITE && PADDR == upfp_pkg::STAT_OFS) begin
        PRDATA[upfp_pkg::STAT_BUSY_BIT]           <= ~idle;
        PRDATA[upfp_pkg::STAT_RXA_BIT]            <= ~link.rx_avail_n;
        PRDATA[upfp_pkg::STAT_TXS_BIT]            <= ~link.tx_space_n;
        PRDATA[upfp_pkg::STAT_PWR_BIT]            <= ~link.power_switch_n;
        PRDATA[upfp_pkg::STAT_DONE_BIT]           <= done_ff;
        PRDATA[upfp_pkg::DATA_LSB +: 8]           <= rdata_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // strobe sequencer
  // ----------------------------------------------------------------
  logic [3:0] cnt_ff;
  logic       rd_n_ff;
  logic       wr_ff;
  logic       hoe_ff;
  logic       wake_oe_ff;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st_ff      <= upfp_pkg::H_IDLE;
      cnt_ff     <= '0;
      rd_n_ff    <= 1'b1;
      wr_ff      <= 1'b0;
      hoe_ff     <= 1'b0;
      wake_oe_ff <= 1'b0;
      wdata_ff   <= 8'h00;
      rdata_ff   <= 8'h00;
      done_ff    <= 1'b0;
    end else begin
      if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
      case (st_ff)
        upfp_pkg::H_IDLE: begin
          // orders arriving while busy are dropped
          if (ctrl_wr && PWDATA[upfp_pkg::CTRL_WR_BIT]) begin
            wdata_ff <= PWDATA[upfp_pkg::DATA_LSB +: 8];
            st_ff    <= upfp_pkg::H_WAIT_TX;
          end else if (ctrl_wr && PWDATA[upfp_pkg::CTRL_RD_BIT]) begin
            done_ff <= 1'b0;
            st_ff   <= upfp_pkg::H_WAIT_RX;
          end else if (ctrl_wr && PWDATA[upfp_pkg::CTRL_WAKE_BIT] &&
                       link.power_switch_n) begin
            wake_oe_ff <= 1'b1; // [R1]
            cnt_ff     <= 4'(upfp_pkg::HOST_WR_CYC);
            st_ff      <= upfp_pkg::H_WAKE;
          end
        end
        upfp_pkg::H_WAIT_TX: begin
          if (!link.tx_space_n) begin
            wr_ff  <= 1'b1; // [R9]
            hoe_ff <= 1'b1;
            cnt_ff <= 4'(upfp_pkg::HOST_WR_CYC); // [R15]
            st_ff  <= upfp_pkg::H_WR;
          end
        end
        upfp_pkg::H_WR: begin
          if (cnt_ff == 4'h1) begin
            wr_ff  <= 1'b0;
            cnt_ff <= 4'h1;
            st_ff  <= upfp_pkg::H_WR_HOLD;
          end
        end
        upfp_pkg::H_WR_HOLD: begin
          hoe_ff <= 1'b0;
          cnt_ff <= 4'(upfp_pkg::HOST_GAP_CYC); // [R16]
          st_ff  <= upfp_pkg::H_GAP;
        end
        upfp_pkg::H_WAIT_RX: begin
          if (!link.rx_avail_n) begin
            rd_n_ff <= 1'b0; // [R10]
            cnt_ff  <= 4'(upfp_pkg::HOST_RD_CYC); // [R12]
            st_ff   <= upfp_pkg::H_RD;
          end
        end
        upfp_pkg::H_RD: begin
          if (cnt_ff == 4'h1) begin
            rdata_ff <= link.fifo_data_bus;
            done_ff  <= 1'b1;
            rd_n_ff  <= 1'b1;
            cnt_ff   <= 4'(upfp_pkg::HOST_GAP_CYC); // [R13]
            st_ff    <= upfp_pkg::H_GAP;
          end
        end
        upfp_pkg::H_WAKE: begin
          if (cnt_ff == 4'h1) begin
            wake_oe_ff <= 1'b0;
            cnt_ff     <= 4'(upfp_pkg::HOST_GAP_CYC);
            st_ff      <= upfp_pkg::H_GAP;
          end
        end
        upfp_pkg::H_GAP: begin
          if (cnt_ff == 4'h1) begin
            st_ff <= upfp_pkg::H_IDLE;
          end
        end
        default: begin
          st_ff <= upfp_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.rd_n     = rd_n_ff;
  assign link.wr       = wr_ff;
  assign link.hdata_o  = wdata_ff;
  assign link.hdata_oe = hoe_ff;
  assign link.hrxf_o   = 1'b0;
  assign link.hrxf_oe  = wake_oe_ff;

endmodule

/* File: testbench/upfp_asserts.sv */
// concurrent checks on the fifo link between the two ends
`timescale 1ns/1ps
module upfp_asserts (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic rd_n,
  input wire logic wr,
  input wire logic hrxf_oe,
  input wire logic ddata_oe,
  input wire logic rxa_oe,
  input wire logic txf_oe,
  input wire logic power_switch_n,
  input wire logic pd_en,
  input wire logic rx_avail_n,
  input wire logic tx_space_n
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  // ------
  // link properties
  // ------
  // two low samples: the first edge in reset may see power-up state
  property p_rst_flags;
    disable iff (1'b0) !RESETN ##1 !RESETN |-> !rxa_oe && !txf_oe;
  endproperty
  a_rst_flags: assert property (p_rst_flags)
    else $error("flag driven during reset");
  property p_rd_drive;
    $fell(rd_n) |-> ##[1:4] ddata_oe;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read data not driven");
  property p_rd_release;
    rd_n [*5] |-> !ddata_oe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("data bus held with strobe high");
  property p_rx_pop;
    $fell(rd_n) && !rx_avail_n |-> ##[1:4] rx_avail_n;
  endproperty
  a_rx_pop: assert property (p_rx_pop)
    else $error("receive flag not raised by read");
  property p_rx_recov;
    $rose(rx_avail_n) |-> rx_avail_n [*2];
  endproperty
  a_rx_recov: assert property (p_rx_recov)
    else $error("receive flag recovery too short");
  property p_tx_busy;
    $rose(wr) |-> ##[0:4] tx_space_n;
  endproperty
  a_tx_busy: assert property (p_tx_busy)
    else $error("transmit flag not raised by write");
  property p_tx_recov;
    $rose(tx_space_n) |-> tx_space_n [*2];
  endproperty
  a_tx_recov: assert property (p_tx_recov)
    else $error("transmit flag recovery too short");
  property p_pd_power;
    pd_en |-> power_switch_n;
  endproperty
  a_pd_power: assert property (p_pd_power)
    else $error("pull-down while power on");
  property p_wake_free;
    hrxf_oe |-> !rxa_oe;
  endproperty
  a_wake_free: assert property (p_wake_free)
    else $error("receive flag driven during wake");
endmodule

/* File: testbench/tb_usb_parallel_fifo_port.sv */
// self-checking bench for the fifo port, both ends joined
`timescale 1ns/1ps
module tb_usb_parallel_fifo_port;
  localparam logic [31:0] ID = 32'h00c0_ffee; // arbitrary value
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic        rxv, rxr, txv, txr, cfg, susp, pdo, tset, resume, wke;
  logic [7:0]  paddr, rxd, txd, tms;
  logic [31:0] pwdata, prdata, cid, q;
  logic [7:0]  txq[$];
  int          bad_count, num_checks, n_res;
  logic [7:0]  rxd_exp [3] = '{8'h5a, 8'ha5, 8'h3c};

  upfp_if lnk ();
  upfp_device #(.MS_CYCLES(20), .CHIP_ID(ID)) i_upfp_device (
    .CLOCK(clk), .RESETN(rst_n), .link(lnk), .USB_RX_VALID(rxv),
    .USB_RX_DATA(rxd), .USB_RX_READY(rxr), .USB_TX_VALID(txv),
    .USB_TX_DATA(txd), .USB_TX_READY(txr), .USB_CONFIGURED(cfg),
    .USB_SUSPEND(susp), .WAKE_ENABLE(wke), .PULLDOWN_OPT(pdo),
    .TIMEOUT_SET(tset), .TIMEOUT_MS(tms), .USB_RESUME(resume),
    .CHIP_ID_OUT(cid));
  upfp_host i_upfp_host (.CLOCK(clk), .RESETN(rst_n), .link(lnk),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));
  upfp_asserts i_upfp_asserts (.CLOCK(clk), .RESETN(rst_n),
    .rd_n(lnk.rd_n), .wr(lnk.wr), .hrxf_oe(lnk.hrxf_oe),
    .ddata_oe(lnk.ddata_oe), .rxa_oe(lnk.rxa_oe), .txf_oe(lnk.txf_oe),
    .power_switch_n(lnk.power_switch_n), .pd_en(lnk.pd_en),
    .rx_avail_n(lnk.rx_avail_n), .tx_space_n(lnk.tx_space_n));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (txv && txr) txq.push_back(txd);
    if (resume) n_res++;
  end

  // ------
  // tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    finish_test();
  endtask
  // request held until pready seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hang();
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin apb(0, upfp_pkg::STAT_OFS, 0); n++; end
      while (q[0] !== 1'b0 && n < 60);
    if (q[0] !== 1'b0) hang();
  endtask
  task automatic op(input logic [31:0] d);
    apb(1, upfp_pkg::CTRL_OFS, d);
    idle();
  endtask
  task automatic urx(input logic [7:0] b);
    int n;
    rxv <= 1;
    rxd <= b;
    n = 0;
    do begin @(posedge clk); n++; end while (rxr !== 1'b1 && n < 50);
    if (rxr !== 1'b1) hang();
    rxv <= 0;
    @(posedge clk);
  endtask

  // ------
  // sequence
  // ------
  initial begin
    {clk, rst_n, psel, penable, pwrite, rxv, cfg, susp, pdo} = '0;
    {tset, txr, paddr, pwdata, rxd, tms, n_res} = '0;
    wke = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk("chip id", cid, ID);
    chk("power idle", lnk.power_switch_n, 1);
    apb(0, upfp_pkg::STAT_OFS, 0);
    chk("status", q[3:0], 4'h4);
    apb(0, 8'h08, 0);
    chk("slverr", e, 1);
    chk("bad rdata", q, 0);
    cfg <= 1;
    repeat (4) @(posedge clk);
    chk("power on", lnk.power_switch_n, 0);
    urx(8'h5a);
    urx(8'ha5);
    urx(8'h3c);
    foreach (rxd_exp[i]) begin
      op(32'h2);
      chk("rx byte", q[15:8], rxd_exp[i]);
      chk("rx done", q[4], 1);
    end
    chk("rx empty", q[1], 0);
    txr <= 1;
    op(32'h7701);
    repeat (260) @(posedge clk);
    chk("early flush", txq.size(), 0);
    repeat (120) @(posedge clk);
    chk("flush dflt", txq.size(), 1);
    tms <= 8'h01;
    tset <= 1;
    txr <= 0;
    @(posedge clk);
    tset <= 0;
    op(32'h1101);
    op(32'h2201);
    repeat (80) @(posedge clk);
    txr <= 1;
    repeat (10) @(posedge clk);
    chk("tx count", txq.size(), 3);
    chk("tx data", {txq[0], txq[1], txq[2]}, 24'h771122);
    susp <= 1;
    pdo <= 1;
    repeat (6) @(posedge clk);
    chk("power susp", lnk.power_switch_n, 1);
    chk("pulled bus", lnk.fifo_data_bus, 8'h00);
    op(32'h4);
    repeat (8) @(posedge clk);
    chk("resume", n_res, 1);
    wke <= 0;
    repeat (2) @(posedge clk);
    chk("wake off", lnk.rxa_oe, 1);
    susp <= 0;
    repeat (6) @(posedge clk);
    chk("power back", lnk.power_switch_n, 0);
    chk("bus free", lnk.fifo_data_bus, 8'hff);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    chk("flags reset", {lnk.rx_avail_n, lnk.tx_space_n}, 2'h3);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    chk("tx after reset", lnk.tx_space_n, 0);
    finish_test();
  end
endmodule
